// File: rtl/smart_card_status_mode_ctrl.sv
// Smart card transmit status flags, mode register and half-duplex character engine
`timescale 1ns/100ps
`include "smart_card_defs.svh"
`default_nettype none
module smart_card_status_mode_ctrl
   import smart_card_pkg::*;
(
   // Clock, reset, enable
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic CE,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [7:0] RDATA,
   // Transfer controller port
   input wire logic DMA_WR_STB,
   input wire logic [7:0] DMA_WR_DATA,
   input wire logic DMA_IS_DTC,
   input wire logic DMA_IRQ_AFTER_TRANSFER_SELECT,
   input wire logic DMA_COUNT_NZ,
   // Card link
   input wire logic CARD_CLK,
   input wire logic IO_IN,
   output logic IO_OUT,
   output logic IO_OE,
   // Status out
   output logic TX_FIFO_READY,
   output logic TX_EMPTY_REQ,
   output logic CARD_MODE
);

   // ********************
   // Declarations
   // ********************
   port_state_s s_reg;
   port_state_s s_next;
   logic [1:0] pins;
   logic line;
   logic clk_rise;
   logic half;
   logic [4:0] ht_inc;
   logic [5:0] detu;
   logic [4:0] tx_end_flag_ht;
   byte_t ssr_val;
   byte_t smart_card_mode_control_val;
   byte_t clr;
   byte_t txb;
   logic push;
   logic dma_clr;
   byte_t f_in;
   logic f_ir;
   logic f_ov;
   byte_t f_od;
   logic pop;

   // ********************
   // Pin synchronisers and buffer
   // ********************
   pin_sync #(.W(2)) u_sync (
      .clk(REF_CLK),
      .rstn(RESETN),
      .ce(CE),
      .d({IO_IN, CARD_CLK}),
      .q(pins)
   );

   assign line = pins[1];

   // Controller word wins the buffer over a register write in the same cycle
   assign push = DMA_WR_STB || (WR_STB && ADDR == `A_TXD);
   assign f_in = DMA_WR_STB ? DMA_WR_DATA : WDATA;

   tx_word_fifo #(.W(8), .D(8)) u_fifo (
      .clk(REF_CLK),
      .rstn(RESETN),
      .ce(CE),
      .in_valid(push),
      .in_ready(f_ir),
      .in_data(f_in),
      .out_valid(f_ov),
      .out_ready(pop),
      .out_data(f_od)
   );

   // ********************
   // Derived values
   // ********************
   // Half etu ticks from card clock rising edges and the baud divider
   assign clk_rise = pins[0] && !s_reg.clk_prev;
   assign half = (s_reg.ph != S_IDLE) && clk_rise && (s_reg.div == s_reg.baud - 8'h01);
   assign ht_inc = s_reg.ht + `HT_ONE;

   // Block mode takes precedence over guard time mode
   assign detu = s_reg.block_transfer_mode ? `TX_END_FLAG_BLK_DETU : (s_reg.gm ? `TX_END_FLAG_GM_DETU : `TX_END_FLAG_NORM_DETU);
   assign tx_end_flag_ht = `HT_REL + 5'(detu / `DETU_PER_HT);

   // Transmit byte after order and inversion
   assign txb = map8(f_od, s_reg.dir, s_reg.data_invert);

   // Start a character only when idle, enabled and no error pending
   assign pop = (s_reg.ph == S_IDLE) && s_reg.card_interface_select && s_reg.te && !s_reg.error_signal_flag && f_ov;

   // A plain DMA write always clears; the other controller only when allowed
   assign dma_clr = DMA_WR_STB && (!DMA_IS_DTC || (!DMA_IRQ_AFTER_TRANSFER_SELECT && DMA_COUNT_NZ));

   // Status and mode read images
   always_comb begin
      ssr_val = 8'h00;
      ssr_val[`B_TX_BUFFER_EMPTY_FLAG] = s_reg.tx_buffer_empty_flag;
      ssr_val[`B_RDRF] = s_reg.rdrf;
      ssr_val[`B_ERS] = s_reg.error_signal_flag;
      ssr_val[`B_PER] = s_reg.per;
      ssr_val[`B_TX_END_FLAG] = s_reg.tx_end_flag;
      ssr_val[`B_MPB] = 1'b0;
      ssr_val[`B_MULTIPROC_TX_BIT] = s_reg.multiproc_tx_bit;
      smart_card_mode_control_val = `SMART_CARD_MODE_CONTROL_ONES;
      smart_card_mode_control_val[`B_DIR] = s_reg.dir;
      smart_card_mode_control_val[`B_INV] = s_reg.data_invert;
      smart_card_mode_control_val[`B_CARD_INTERFACE_SELECT] = s_reg.card_interface_select;
   end

   // ********************
   // Next state
   // ********************
   // Clears are applied first so that a hardware set in the same cycle wins
   always_comb begin
      s_next = s_reg;
      clr = 8'h00;
      s_next.clk_prev = pins[0];
      s_next.fifo_rdy = f_ir;
      s_next.rdata = 8'h00;

      // Register writes
      if (WR_STB) begin
         case (ADDR)
            `A_SSR: begin
               // Only a flag seen as one by the last status read can be cleared
               clr = s_reg.armed & ~WDATA;
               s_next.armed = 8'h00;
               s_next.multiproc_tx_bit = WDATA[`B_MULTIPROC_TX_BIT];
            end
            `A_SMART_CARD_MODE_CONTROL: begin
               s_next.dir = WDATA[`B_DIR];
               s_next.data_invert = WDATA[`B_INV];
               s_next.card_interface_select = WDATA[`B_CARD_INTERFACE_SELECT];
            end
            `A_CTRL: begin
               // Dropping receive enable leaves the error flag alone
               s_next.te = WDATA[`B_TE];
               s_next.re = WDATA[`B_RE];
               s_next.gm = WDATA[`B_GM];
               s_next.block_transfer_mode = WDATA[`B_BLK];
               s_next.odd = WDATA[`B_ODD];
            end
            `A_BAUD: begin
               s_next.baud = WDATA;
            end
            default: begin
            end
         endcase
      end

      // Register reads, data in the following cycle only
      if (RD_STB) begin
         case (ADDR)
            `A_SSR: begin
               s_next.rdata = ssr_val;
               s_next.armed = ssr_val;
            end
            `A_SMART_CARD_MODE_CONTROL: s_next.rdata = smart_card_mode_control_val;
            `A_CTRL: begin
               s_next.rdata[`B_TE] = s_reg.te;
               s_next.rdata[`B_RE] = s_reg.re;
               s_next.rdata[`B_GM] = s_reg.gm;
               s_next.rdata[`B_BLK] = s_reg.block_transfer_mode;
               s_next.rdata[`B_ODD] = s_reg.odd;
            end
            `A_RXD: s_next.rdata = s_reg.rxd;
            `A_BAUD: s_next.rdata = s_reg.baud;
            default: s_next.rdata = 8'h00;
         endcase
      end

      // Flag clears; transmit end has no write path of its own
      if (clr[`B_TX_BUFFER_EMPTY_FLAG] || dma_clr) begin
         s_next.tx_buffer_empty_flag = 1'b0;
         s_next.tx_end_flag = 1'b0;
      end
      if (clr[`B_ERS]) begin
         s_next.error_signal_flag = 1'b0;
      end
      if (clr[`B_PER]) begin
         s_next.per = 1'b0;
      end
      if (clr[`B_RDRF]) begin
         s_next.rdrf = 1'b0;
      end

      // Divider runs only inside a character
      if (s_reg.ph == S_IDLE) begin
         s_next.div = 8'h00;
      end else if (clk_rise) begin
         s_next.div = half ? 8'h00 : s_reg.div + 8'h01;
      end

      // Character engine
      case (s_reg.ph)
         S_IDLE: begin
            if (pop) begin
               // Buffer word moved to the shifter, so the buffer reads empty again
               s_next.ph = S_TX;
               s_next.ht = 5'h00;
               s_next.sh = txb;
               s_next.par = (^txb) ^ s_reg.odd;
               s_next.io_oe = 1'b1;
               s_next.tx_buffer_empty_flag = 1'b1;
            end else if (s_reg.card_interface_select && s_reg.re && !line) begin
               s_next.ph = S_RX;
               s_next.ht = 5'h00;
            end
         end
         S_TX: begin
            if (half) begin
               s_next.ht = ht_inc;
               if (ht_inc >= `HT_DFIRST && ht_inc <= `HT_DLAST && !ht_inc[0]) begin
                  // Line is open drain: drive only for a zero
                  s_next.io_oe = !s_reg.sh[0];
                  s_next.sh = s_reg.sh >> 1;
               end
               if (ht_inc == `HT_PAR) begin
                  s_next.io_oe = !s_reg.par;
               end
               if (ht_inc == `HT_REL) begin
                  s_next.io_oe = 1'b0;
               end
               if (ht_inc == `HT_ERRS && !line) begin
                  s_next.error_signal_flag = 1'b1;
               end
               if (ht_inc == tx_end_flag_ht) begin
                  s_next.ph = S_IDLE;
                  if (!s_next.error_signal_flag && s_next.tx_buffer_empty_flag) begin
                     s_next.tx_end_flag = 1'b1;
                  end
               end
            end
         end
         S_RX: begin
            if (half) begin
               s_next.ht = ht_inc;
               if (ht_inc == `HT_ONE && line) begin
                  // Glitch rather than a start bit
                  s_next.ph = S_IDLE;
               end
               if (ht_inc > `HT_DFIRST && ht_inc <= `HT_RXDLAST && ht_inc[0]) begin
                  s_next.sh = {line, s_reg.sh[7:1]};
               end
               if (ht_inc == `HT_RXPAR) begin
                  // Parity checks line levels, so inversion has no effect on it
                  s_next.rxd = map8(s_reg.sh, s_reg.dir, s_reg.data_invert);
                  if (((^s_reg.sh) ^ s_reg.odd) != line) begin
                     s_next.per = 1'b1;
                  end else begin
                     s_next.rdrf = 1'b1;
                  end
               end
               if (ht_inc == `HT_REL) begin
                  s_next.ph = S_IDLE;
               end
            end
         end
         default: s_next.ph = S_IDLE;
      endcase

      // Transmitter off and no error keeps the end flag up
      if (!s_reg.te && !s_reg.error_signal_flag) begin
         s_next.tx_end_flag = 1'b1;
      end
   end

   // ********************
   // State register
   // ********************
   // Clock enable low freezes everything, strobes included
   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         s_reg <= '0;
         s_reg.tx_buffer_empty_flag <= 1'b1;
         s_reg.tx_end_flag <= 1'b1;
         s_reg.baud <= `BAUD_RST;
      end else if (CE) begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register
   assign RDATA = s_reg.rdata;
   assign IO_OUT = s_reg.clk_prev & 1'b0;
   assign IO_OE = s_reg.io_oe;
   assign TX_FIFO_READY = s_reg.fifo_rdy;
   assign TX_EMPTY_REQ = s_reg.tx_buffer_empty_flag;
   assign CARD_MODE = s_reg.card_interface_select;

   // ********************
   // Assertions
   // ********************
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   sequence s_tx_start;
      CE && pop;
   endsequence

   sequence s_err_sample;
      CE && s_reg.ph == S_TX && half && ht_inc == `HT_ERRS && !line;
   endsequence

   property p_tx_end_flag_te_off;
      CE && !s_reg.te && !s_reg.error_signal_flag |=> s_reg.tx_end_flag;
   endproperty
   a_tx_end_flag_te_off: assert property (p_tx_end_flag_te_off) else $error("end flag not set with transmitter off");

   property p_frame_end;
      CE && s_reg.ph == S_TX && s_next.ph == S_IDLE |-> s_reg.ht + `HT_ONE == `HT_REL + 5'(detu / `DETU_PER_HT);
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("character ended at wrong tick");

   property p_sw_clear;
      CE && WR_STB && ADDR == `A_SSR && s_reg.armed[`B_TX_BUFFER_EMPTY_FLAG] && !WDATA[`B_TX_BUFFER_EMPTY_FLAG] && s_reg.te
         && s_reg.ph == S_IDLE |=> !s_reg.tx_end_flag;
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("end flag survived zero write");

   property p_dma_clear;
      CE && DMA_WR_STB && !DMA_IS_DTC && s_reg.te && s_reg.ph == S_IDLE |=> !s_reg.tx_end_flag;
   endproperty
   a_dma_clear: assert property (p_dma_clear) else $error("end flag survived controller write");

   property p_dtc_hold;
      CE && DMA_WR_STB && DMA_IS_DTC && DMA_IRQ_AFTER_TRANSFER_SELECT && s_reg.tx_end_flag && !WR_STB |=> s_reg.tx_end_flag;
   endproperty
   a_dtc_hold: assert property (p_dtc_hold) else $error("end flag cleared with disable set");

   property p_mpb_zero;
      CE && RD_STB && ADDR == `A_SSR |=> !RDATA[`B_MPB];
   endproperty
   a_mpb_zero: assert property (p_mpb_zero) else $error("multiprocessor bit read as one");

   property p_mode_ones;
      CE && RD_STB && ADDR == `A_SMART_CARD_MODE_CONTROL |=> (RDATA & `SMART_CARD_MODE_CONTROL_ONES) == `SMART_CARD_MODE_CONTROL_ONES;
   endproperty
   a_mode_ones: assert property (p_mode_ones) else $error("reserved mode bits not one");

   property p_msb_first;
      s_tx_start and (s_reg.dir && !s_reg.data_invert) |=> s_reg.sh[0] == $past(f_od[7]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first bit not the msb");

   property p_invert;
      s_tx_start and (!s_reg.dir && s_reg.data_invert) |=> s_reg.sh == ~$past(f_od);
   endproperty
   a_invert: assert property (p_invert) else $error("transmit data not inverted");

   property p_parity;
      s_tx_start |=> s_reg.par == ((^$past(f_od)) ^ $past(s_reg.odd));
   endproperty
   a_parity: assert property (p_parity) else $error("parity follows inversion");

   property p_mode_off;
      CE && !s_reg.card_interface_select && s_reg.ph == S_IDLE |=> s_reg.ph == S_IDLE;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("character started outside card mode");

   property p_err_set;
      s_err_sample |=> s_reg.error_signal_flag ##1 (s_reg.error_signal_flag || !CE || WR_STB);
   endproperty
   a_err_set: assert property (p_err_set) else $error("error signal not recorded");

   property p_re_keeps;
      CE && WR_STB && ADDR == `A_CTRL && !WDATA[`B_RE] && s_reg.error_signal_flag |=> s_reg.error_signal_flag;
   endproperty
   a_re_keeps: assert property (p_re_keeps) else $error("receive disable cleared error flag");

endmodule
`default_nettype wire

// File: include/smart_card_defs.svh
// Register map, field positions, reset values and frame timing for the card port
`ifndef SMART_CARD_DEFS_SVH
`define SMART_CARD_DEFS_SVH

// ********************
// Register offsets
// ********************
`define A_SSR 8'h00
`define A_SMART_CARD_MODE_CONTROL 8'h01
`define A_CTRL 8'h02
`define A_TXD 8'h03
`define A_RXD 8'h04
`define A_BAUD 8'h05

// ********************
// Status register fields
// ********************
`define B_TX_BUFFER_EMPTY_FLAG 7
`define B_RDRF 6
`define B_ERS 4
`define B_PER 3
`define B_TX_END_FLAG 2
`define B_MPB 1
`define B_MULTIPROC_TX_BIT 0

// ********************
// Control and mode fields
// ********************
`define B_TE 5
`define B_RE 4
`define B_GM 3
`define B_BLK 2
`define B_ODD 1
`define B_DIR 3
`define B_INV 2
`define B_CARD_INTERFACE_SELECT 0
`define SMART_CARD_MODE_CONTROL_ONES 8'hF2
`define BAUD_RST 8'hBA

// ********************
// Frame timing in half etu ticks from the start bit
// ********************
`define HT_ONE 5'h01
`define HT_DFIRST 5'h02
`define HT_DLAST 5'h10
`define HT_RXDLAST 5'h11
`define HT_PAR 5'h12
`define HT_RXPAR 5'h13
`define HT_REL 5'h14
`define HT_ERRS 5'h15

// ********************
// Transmit end delays in tenths of an etu after the frame
// ********************
`define TX_END_FLAG_NORM_DETU 6'h19
`define TX_END_FLAG_GM_DETU 6'h0F
`define TX_END_FLAG_BLK_DETU 6'h0A
`define DETU_PER_HT 6'h05

`endif

// File: include/smart_card_pkg.sv
// Types and helpers shared by the card port design
`default_nettype none
package smart_card_pkg;

   typedef logic [7:0] byte_t;

   typedef enum logic [1:0] {S_IDLE, S_TX, S_RX} phase_e;

   // Whole state of the card port
   typedef struct packed {
      phase_e ph;
      logic [4:0] ht;
      byte_t div;
      byte_t sh;
      logic par;
      logic clk_prev;
      logic tx_buffer_empty_flag;
      logic rdrf;
      logic error_signal_flag;
      logic per;
      logic tx_end_flag;
      logic multiproc_tx_bit;
      byte_t armed;
      logic te;
      logic re;
      logic gm;
      logic block_transfer_mode;
      logic odd;
      logic dir;
      logic data_invert;
      logic card_interface_select;
      byte_t baud;
      byte_t rxd;
      byte_t rdata;
      logic io_oe;
      logic fifo_rdy;
   } port_state_s;

   // Bit order and inversion; the same map serves both directions
   function automatic byte_t map8(input byte_t b, input logic rev, input logic data_invert);
      byte_t r;
      for (int i = 0; i < 8; i++) begin
         r[i] = rev ? b[7 - i] : b[i];
      end
      return data_invert ? ~r : r;
   endfunction

endpackage
`default_nettype wire

// File: rtl/pin_sync.sv
// Two stage synchroniser for pins coming from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   // Clock and control
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Pins in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_s;

   sync_s s_reg;
   sync_s s_next;

   // First stage feeds only the second stage
   always_comb begin
      s_next = s_reg;
      s_next.meta = d;
      s_next.q = s_reg.meta;
   end

   // Registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_reg <= '0;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign q = s_reg.q;

endmodule
`default_nettype wire

// File: rtl/tx_word_fifo.sv
// Transmit word buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module tx_word_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and control
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);

   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_s;

   fifo_s f_reg;
   fifo_s f_next;
   logic push;
   logic pop;

   // Flags come from the count register, so full and empty never lie
   assign in_ready = (f_reg.cnt != (AW + 1)'(D));
   assign out_valid = (f_reg.cnt != '0);
   assign out_data = f_reg.mem[f_reg.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer and count update
   always_comb begin
      f_next = f_reg;
      if (push) begin
         f_next.mem[f_reg.wp] = in_data;
         f_next.wp = (f_reg.wp == (AW)'(D - 1)) ? '0 : f_reg.wp + 1'b1;
      end
      if (pop) begin
         f_next.rp = (f_reg.rp == (AW)'(D - 1)) ? '0 : f_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         f_next.cnt = f_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         f_next.cnt = f_reg.cnt - 1'b1;
      end
   end

   // Registers
   always_ff @(posedge clk) begin
      if (!rstn) begin
         f_reg <= '0;
      end else if (ce) begin
         f_reg <= f_next;
      end
   end

endmodule
`default_nettype wire

// File: tb/card_partner.sv
// Behavioural smart card on the open-drain data line, with its clock
`timescale 1ns/100ps
`default_nettype none
module card_partner (
   // Link pins
   input wire logic run,
   input wire logic dev_oe,
   output logic card_clk,
   output logic line,
   // Commands
   input wire logic nack,
   input wire logic send,
   input wire logic [8:0] send_bits,
   // Capture
   output logic [7:0] got_data,
   output logic got_par,
   output var int frames,
   output var int rises
);
   // ********************
   // Card side
   // ********************
   logic pull_err = 1'b0;
   logic pull_tx = 1'b0;
   logic sending = 1'b0;
   int nfr = 0;
   // Pull-up wins unless either side pulls low, so a released line never floats
   assign line = ~(dev_oe | pull_err | pull_tx);
   assign frames = nfr;
   // Clock parks low while run is low; rises lets the bench time events in half etu ticks
   initial begin
      card_clk = 1'b0;
      rises = 0;
      forever begin
         #24;
         if (run || card_clk) begin
            card_clk = ~card_clk;
            if (card_clk) rises++;
         end
      end
   end
   // Sample mid-bit on the falling edge; half a tick of margin covers sync lag
   always @(negedge line) begin
      if (!sending && !pull_err) begin
         for (int n = 1; n <= 22; n++) begin
            @(posedge card_clk);
            @(negedge card_clk);
            if (n >= 3 && n <= 17 && n % 2 == 1) got_data[(n - 3) / 2] = line;
            if (n == 19) begin
               got_par = line;
               nfr++;
               pull_err = nack; // Error signal spans both possible sample ticks
            end
            if (n == 22) pull_err = 1'b0;
         end
      end
   end
   // Send start, eight data bits, parity, then release the line
   always @(posedge send) begin
      sending = 1'b1;
      @(negedge card_clk);
      pull_tx = 1'b1;
      for (int b = 0; b < 10; b++) begin
         repeat (2) @(negedge card_clk);
         pull_tx = (b < 9) ? ~send_bits[b] : 1'b0;
      end
      repeat (4) @(negedge card_clk);
      sending = 1'b0;
   end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the smart card status and mode block
`timescale 1ns/100ps
`include "smart_card_defs.svh"
`default_nettype none
module tb_top;
   // ********************
   // Bench
   // ********************
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0, nack = 1'b0, send = 1'b0;
   logic dwr = 1'b0, data_transfer_ctrl = 1'b0, dsel = 1'b0, dnz = 1'b0, ce = 1'b1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, ddata = 8'h00;
   logic [8:0] send_bits = 9'h000;
   logic [7:0] rdata, got_data;
   logic oe, io_out, fifo_rdy, empty_req, card_mode, line, card_clk, got_par;
   int frames, rises, bad_count = 0, checks_done = 0;

   smart_card_status_mode_ctrl dut (
      .REF_CLK(clk), .RESETN(rstn), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR_STB(wr), .RD_STB(rd),
      .RDATA(rdata), .DMA_WR_STB(dwr), .DMA_WR_DATA(ddata), .DMA_IS_DTC(data_transfer_ctrl), .DMA_IRQ_AFTER_TRANSFER_SELECT(dsel),
      .DMA_COUNT_NZ(dnz), .CARD_CLK(card_clk), .IO_IN(line), .IO_OUT(io_out), .IO_OE(oe),
      .TX_FIFO_READY(fifo_rdy), .TX_EMPTY_REQ(empty_req), .CARD_MODE(card_mode)
   );
   card_partner card (
      .run(run), .dev_oe(oe), .card_clk(card_clk), .line(line), .nack(nack), .send(send),
      .send_bits(send_bits), .got_data(got_data), .got_par(got_par), .frames(frames), .rises(rises)
   );

   // 250 MHz system clock
   initial begin
      forever #2 clk = ~clk;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bus cycles keep one idle edge after each strobe so no strobe is set twice at once
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask
   task automatic rchk(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      chk(what, exp, d & m);
   endtask
   task automatic poll(input logic [7:0] m, output logic [7:0] d);
      for (int i = 0; i < 500; i++) begin
         rd_reg(`A_SSR, d);
         if ((d & m) === m) return;
      end
      chk("status wait", m, d & m);
   endtask
   task automatic clr_all();
      logic [7:0] d;
      rd_reg(`A_SSR, d);
      wr_reg(`A_SSR, 8'h00);
   endtask
   task automatic dma(input logic is_dtc, input logic sel, input logic nz);
      data_transfer_ctrl <= is_dtc;
      dsel <= sel;
      dnz <= nz;
      ddata <= 8'h5A;
      dwr <= 1'b1;
      @(posedge clk);
      dwr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic t_reset();
      rchk("status", `A_SSR, 8'hFF, 8'h84);
      rchk("mode", `A_SMART_CARD_MODE_CONTROL, 8'hFF, `SMART_CARD_MODE_CONTROL_ONES);
      chk("card mode pin", 8'h00, {7'h00, card_mode});
      rchk("unmapped", 8'h06, 8'hFF, 8'h00);
      wr_reg(`A_SSR, 8'hFA);
      rchk("end flag kept", `A_SSR, 8'hFF, 8'h84);
   endtask
   // A write made while the clock enable is low must be lost
   task automatic t_mode();
      ce <= 1'b0;
      wr_reg(`A_SMART_CARD_MODE_CONTROL, 8'h0D);
      ce <= 1'b1;
      rchk("frozen write", `A_SMART_CARD_MODE_CONTROL, 8'hFF, `SMART_CARD_MODE_CONTROL_ONES);
      wr_reg(`A_SMART_CARD_MODE_CONTROL, 8'h0D);
      rchk("mode set", `A_SMART_CARD_MODE_CONTROL, 8'hFF, 8'hFF);
      chk("card mode on", 8'h01, {7'h00, card_mode});
      wr_reg(`A_SMART_CARD_MODE_CONTROL, 8'h00);
      rchk("mode clear", `A_SMART_CARD_MODE_CONTROL, 8'hFF, `SMART_CARD_MODE_CONTROL_ONES);
   endtask
   task automatic t_clear();
      wr_reg(`A_CTRL, 8'h20);
      clr_all();
      rchk("flags cleared", `A_SSR, 8'hFF, 8'h00);
      chk("empty req", 8'h00, {7'h00, empty_req});
      wr_reg(`A_CTRL, 8'h00);
      rchk("end set idle", `A_SSR, 8'hFF, 8'h04);
   endtask
   // Controller writes land in the buffer; card mode is off so nothing drains
   task automatic t_dma();
      wr_reg(`A_CTRL, 8'h20);
      dma(1'b1, 1'b1, 1'b1);
      rchk("dtc disabled", `A_SSR, 8'h04, 8'h04);
      dma(1'b1, 1'b0, 1'b0);
      rchk("dtc count zero", `A_SSR, 8'h04, 8'h04);
      dma(1'b0, 1'b0, 1'b0);
      rchk("dma clears", `A_SSR, 8'h04, 8'h00);
      wr_reg(`A_CTRL, 8'h00);
      wr_reg(`A_CTRL, 8'h20);
      dma(1'b1, 1'b0, 1'b1);
      rchk("dtc clears", `A_SSR, 8'h04, 8'h00);
   endtask
   task automatic t_fill();
      int n;
      int f0;
      n = 4;
      #1;
      while (fifo_rdy === 1'b1 && n < 12) begin
         @(posedge clk);
         wr_reg(`A_TXD, 8'hC3);
         n++;
         #1;
      end
      chk("buffer depth", 8'h08, n[7:0]);
      @(posedge clk);
      wr_reg(`A_TXD, 8'h77);
      f0 = frames;
      wr_reg(`A_BAUD, 8'h01);
      run <= 1'b1;
      wr_reg(`A_SMART_CARD_MODE_CONTROL, 8'h01);
      for (int i = 0; i < 5000 && frames < f0 + 9; i++) @(posedge clk);
      chk("frames drained", 8'h08, 8'(frames - f0));
   endtask
   // One character per guard and block combination, each with its own order and invert
   task automatic t_tx();
      logic [7:0] ctl [4] = '{8'h20, 8'h2A, 8'h24, 8'h2E};
      logic [7:0] mode [4] = '{8'h01, 8'h09, 8'h05, 8'h0D};
      int ticks [4] = '{25, 23, 22, 22};
      logic [7:0] v;
      logic [7:0] lb;
      logic [7:0] d;
      int r0;
      v = 8'h35;
      for (int c = 0; c < 4; c++) begin
         clr_all();
         wr_reg(`A_CTRL, ctl[c]);
         wr_reg(`A_SMART_CARD_MODE_CONTROL, mode[c]);
         @(negedge card_clk);
         @(posedge clk);
         wr_reg(`A_TXD, v);
         r0 = rises;
         poll(8'h04, d);
         chk("end delay", ticks[c][7:0], 8'(rises - r0));
         chk("empty at end", 8'h80, d & 8'h80);
         for (int k = 0; k < 8; k++) lb[k] = (mode[c][3] ? v[7 - k] : v[k]) ^ mode[c][2];
         chk("line data", lb, got_data);
         chk("line parity", {7'h00, ^lb ^ ctl[c][1]}, {7'h00, got_par});
         chk("drive level", 8'h00, {7'h00, io_out});
      end
      chk("empty req", 8'h01, {7'h00, empty_req});
   endtask
   task automatic t_err();
      logic [7:0] d;
      nack <= 1'b1;
      clr_all();
      wr_reg(`A_CTRL, 8'h20);
      wr_reg(`A_SMART_CARD_MODE_CONTROL, 8'h01);
      wr_reg(`A_TXD, 8'hA5);
      poll(8'h10, d);
      nack <= 1'b0;
      repeat (120) @(posedge clk);
      wr_reg(`A_CTRL, 8'h30);
      wr_reg(`A_CTRL, 8'h20);
      rchk("error kept", `A_SSR, 8'h14, 8'h10);
      wr_reg(`A_SSR, 8'hEE);
      rchk("error cleared", `A_SSR, 8'h10, 8'h00);
   endtask
   task automatic t_rx();
      logic [7:0] v;
      logic [7:0] e;
      logic [7:0] d;
      v = 8'h3B;
      for (int k = 0; k < 8; k++) e[7 - k] = ~v[k];
      wr_reg(`A_CTRL, 8'h10);
      wr_reg(`A_SMART_CARD_MODE_CONTROL, 8'h0D);
      send_bits <= {^v, v};
      send <= 1'b1;
      poll(8'h40, d);
      send <= 1'b0;
      chk("mp bit", 8'h00, d & 8'h02);
      rchk("received byte", `A_RXD, 8'hFF, e);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Main sequence after eight reset cycles
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_mode();
      t_clear();
      t_dma();
      t_fill();
      t_tx();
      t_err();
      t_rx();
      final_report();
   end
   // Watchdog well beyond the expected run of about seven thousand cycles
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
